/* hw/ordinary_bus_pkg.sv */
// Shared constants and carrier types for the ordinary-space bus cycle generator
package ordinary_bus_pkg;

	// ----------------------------------------------------------------
	// Access sizes and device widths
	// ----------------------------------------------------------------
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;

	// ----------------------------------------------------------------
	// Wait field codes and counts
	// ----------------------------------------------------------------
	localparam logic [1:0] WAIT_NONE = 2'h0;
	localparam logic [1:0] WAIT_SOFT_A = 2'h1;
	localparam logic [1:0] WAIT_SOFT_B = 2'h2;
	localparam logic [1:0] WAIT_LONG = 2'h3;
	localparam logic [3:0] SOFT_WAITS_A = 4'h1;
	localparam logic [3:0] SOFT_WAITS_B = 4'h2;
	// Long-wait code 7..0 to wait count, 0 to 14
	localparam logic [31:0] LONG_WAIT_TABLE = 32'he_a_6_4_3_2_1_0;
	// Space 4 release delay code 3..0 to cycles
	localparam logic [15:0] SP4_RELEASE_TABLE = 16'h4_4_2_1;
	// Space 4 hold idle code 3..0 to cycles, 0 to 5
	localparam logic [15:0] SP4_HOLD_TABLE = 16'h5_3_1_0;
	localparam logic [3:0] MAX_SHARED_IDLE = 4'h2;
	localparam logic [2:0] SPACE_4 = 3'h4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [24:0] RESET_ADDR = 25'h0;
	localparam logic [31:0] RESET_DATA = 32'h0;
	localparam logic [4:0] RESET_CS_N = 5'h1f;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_FIRST = 3'h3,
		ST_WAIT = 3'h2,
		ST_SECOND = 3'h6,
		ST_HOLD = 3'h7
	} bus_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] size;
		logic [2:0] space;
		logic [24:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [4:0][1:0] dev_width;
		logic [4:0][1:0] wait_field;
		logic [2:0] long_wait_sp0;
		logic [2:0] long_wait_sp1;
		logic [2:0] shared_long_wait_sp23;
		logic [2:0] long_wait_sp4;
		logic [4:0] external_wait_mask;
		logic [1:0] sp4_wait_release_delay;
		logic [3:0][1:0] setup_hold_idle;
		logic [2:0] sp4_setup_idle_count;
		logic [1:0] sp4_hold_idle_count;
		logic ratio_one_to_one;
	} bus_cfg_t;

	typedef struct packed {
		logic [24:0] addr;
		logic bus_start_strobe_n;
		logic read_strobe_n;
		logic [3:0] byte_write_strobe_n;
		logic rd_wr_n;
		logic [31:0] data_out;
		logic data_oe;
	} bus_pins_t;

	typedef struct packed {
		logic ready;
		logic rvalid;
		logic last;
		logic [31:0] rdata;
	} bus_resp_t;

endpackage

/* hw/fall_edge_stage.sv */
// Falling-edge flops: wait pin sample and chip select drive
`timescale 1ns/1ps
module fall_edge_stage
	import ordinary_bus_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wait_pin_n,
	input wire logic [4:0] cs_request,
	output logic wait_active,
	output logic [4:0] space_chip_select_n
);

	typedef struct packed {
		logic wait_fall_n;
		logic [4:0] cs_n;
	} fall_state_t;

	fall_state_t st;
	fall_state_t next_st;

	always_comb begin
		next_st.wait_fall_n = wait_pin_n;
		next_st.cs_n = ~cs_request;
	end

	always_ff @(negedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st <= {1'b1, RESET_CS_N};
		end else begin
			st <= next_st;
		end
	end

	// Single flop, half a cycle to settle; a second would sample before the last wait
	assign wait_active = ~st.wait_fall_n;
	assign space_chip_select_n = st.cs_n;

endmodule // fall_edge_stage

/* hw/ordinary_space_ctrl.sv */
// Ordinary-space bus cycle generator for SRAM-like external devices
// Functional notes
// - No-wait access takes two cycles, first state then second state.
// - Bus-start strobe goes low for exactly one cycle per bus cycle.
// - Chip select deasserts on the falling clock edge within the piece's last cycle (second state, or last hold idle cycle).
// - Reads carry no size; full device width read at true start address.
// - 32-bit writes: strobe 3 is byte 4n, strobe 0 is byte 4n+3.
// - 16-bit: strobe 1 is 2n, strobe 0 is 2n+1; 8-bit uses strobe 0.
// - Direction output rests at read level when idle.
// - Wide accesses to narrow devices split into consecutive bus accesses.
// - At ratio 1:1 split pieces burst without chip select gap.
// - Wait field 01 or 10 inserts that many software wait states.
// - Wait field 11 takes wait count from long-wait field, 0 to 14.
// - Spaces 0,1,4 have own long-wait fields; spaces 2,3 share one.
// - Wait pin sampled only with software waits and mask bit clear.
// - Wait pin sampled only on leaving the last wait state.
// - Wait pin sampled on the falling clock edge.
// - Spaces 0-3 release strobes one cycle after wait release.
// - Space 4 release delay is 1, 2 or 4 cycles by field.
// - Set-up and hold idle keep signals but not read/write strobes.
// - Write data stays driven through trailing hold idle cycles.
// - Spaces 0-3 set-up and hold idle equal, 0 to 2 cycles.
// - Space 4 set-up idle 0 to 7, hold idle 0 to 5.
`timescale 1ns/1ps
module ordinary_space_ctrl
	import ordinary_bus_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input bus_req_t req,
	input bus_cfg_t cfg,
	input wire logic wait_pin_n,
	input wire logic [31:0] bus_data_in,
	output bus_resp_t resp,
	output bus_pins_t pins,
	output logic [4:0] space_chip_select_n
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		bus_state_t phase;
		logic [3:0] cnt;
		logic [1:0] piece;
		logic [1:0] last_piece;
		logic write;
		logic [1:0] size;
		logic [2:0] space;
		logic [1:0] width;
		logic [24:0] addr;
		logic [31:0] wdata;
		bus_pins_t pins;
		bus_resp_t resp;
	} ctrl_state_t;

	ctrl_state_t st;
	ctrl_state_t next_st;
	logic wait_active;
	logic [4:0] cs_request;
	logic piece_end;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// last piece index, one less than the piece count
	function automatic logic [1:0] last_piece_of(input logic [1:0] size,
			input logic [1:0] width);
		logic [1:0] r;
		r = 2'h0;
		if (width == WIDTH_8) begin
			r = (size == SIZE_LONG) ? 2'h3 : (size == SIZE_WORD) ? 2'h1 : 2'h0;
		end else if (width == WIDTH_16 && size == SIZE_LONG) begin
			r = 2'h1;
		end
		return r;
	endfunction

	function automatic logic [3:0] wait_count(input bus_cfg_t c, input logic [2:0] sp);
		logic [2:0] lw;
		logic [3:0] r;
		case (sp)
			3'h0: lw = c.long_wait_sp0;
			3'h1: lw = c.long_wait_sp1;
			3'h4: lw = c.long_wait_sp4;
			default: lw = c.shared_long_wait_sp23;
		endcase
		case (c.wait_field[sp])
			WAIT_SOFT_A: r = SOFT_WAITS_A;
			WAIT_SOFT_B: r = SOFT_WAITS_B;
			WAIT_LONG: r = LONG_WAIT_TABLE[{lw, 2'h0} +: 4];
			default: r = 4'h0;
		endcase
		return r;
	endfunction

	function automatic logic [3:0] idle_count(input bus_cfg_t c, input logic [2:0] sp,
			input logic hold);
		logic [3:0] r;
		if (sp == SPACE_4) begin
			r = hold ? SP4_HOLD_TABLE[{c.sp4_hold_idle_count, 2'h0} +: 4]
				: {1'b0, c.sp4_setup_idle_count};
		end else begin
			r = {2'h0, c.setup_hold_idle[sp[1:0]]};
			if (r > MAX_SHARED_IDLE) begin
				r = MAX_SHARED_IDLE;
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] lane_mask(input logic [1:0] width, input logic [1:0] size,
			input logic [1:0] a);
		logic [3:0] r;
		r = 4'h1;
		if (width == WIDTH_32) begin
			if (size == SIZE_BYTE) begin
				r = 4'h8 >> a;
			end else if (size == SIZE_WORD) begin
				r = a[1] ? 4'h3 : 4'hc;
			end else begin
				r = 4'hf;
			end
		end else if (width == WIDTH_16) begin
			r = (size == SIZE_BYTE) ? (a[0] ? 4'h1 : 4'h2) : 4'h3;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] waits;
		logic [3:0] idle;
		logic ext_wait_en;
		logic [4:0] shift;
		logic [3:0] mask;
		waits = wait_count(cfg, st.space);
		idle = 4'h0;
		shift = 5'h0;
		mask = 4'h0;
		// sampling only with software waits and unmasked
		ext_wait_en = (cfg.wait_field[st.space] == WAIT_SOFT_A
			|| cfg.wait_field[st.space] == WAIT_SOFT_B)
			&& !cfg.external_wait_mask[st.space];
		next_st = st;
		next_st.resp.rvalid = 1'b0;
		piece_end = 1'b0;
		case (st.phase)
			ST_IDLE: begin
				if (req.valid && st.resp.ready) begin
					next_st.write = req.write;
					next_st.size = req.size;
					next_st.space = req.space;
					next_st.width = cfg.dev_width[req.space];
					next_st.addr = req.addr;
					next_st.wdata = req.wdata;
					next_st.piece = 2'h0;
					next_st.last_piece = last_piece_of(req.size, cfg.dev_width[req.space]);
					idle = idle_count(cfg, req.space, 1'b0);
					next_st.phase = (idle != 4'h0) ? ST_SETUP : ST_FIRST;
					next_st.cnt = idle - 4'h1;
				end
			end
			ST_SETUP: begin
				if (st.cnt == 4'h0) begin
					next_st.phase = ST_FIRST;
				end else begin
					next_st.cnt = st.cnt - 4'h1;
				end
			end
			ST_FIRST: begin
				// no waits goes straight to second state
				next_st.phase = (waits == 4'h0) ? ST_SECOND : ST_WAIT;
				next_st.cnt = waits;
			end
			ST_WAIT: begin
				if (st.cnt > 4'h1) begin
					next_st.cnt = st.cnt - 4'h1;
				end else if (!(ext_wait_en && wait_active)) begin
					next_st.phase = ST_SECOND;
					next_st.cnt = 4'h0;
					if (ext_wait_en && st.space == SPACE_4) begin
						next_st.cnt = SP4_RELEASE_TABLE[{cfg.sp4_wait_release_delay, 2'h0} +: 4]
							- 4'h1;
					end
				end
			end
			ST_SECOND: begin
				if (st.cnt != 4'h0) begin
					next_st.cnt = st.cnt - 4'h1;
				end else begin
					next_st.resp.rvalid = !st.write;
					next_st.resp.rdata = bus_data_in;
					next_st.resp.last = (st.piece == st.last_piece);
					idle = idle_count(cfg, st.space, 1'b1);
					if (st.piece != st.last_piece && cfg.ratio_one_to_one) begin
						next_st.phase = ST_FIRST;
						next_st.piece = st.piece + 2'h1;
					end else if (idle != 4'h0) begin
						next_st.phase = ST_HOLD;
						next_st.cnt = idle - 4'h1;
					end else begin
						piece_end = 1'b1;
					end
				end
			end
			ST_HOLD: begin
				if (st.cnt != 4'h0) begin
					next_st.cnt = st.cnt - 4'h1;
				end else begin
					piece_end = 1'b1;
				end
			end
			default: begin
				next_st.phase = ST_IDLE;
			end
		endcase
		// non-burst pieces repeat the basic cycle
		if (piece_end) begin
			if (st.piece != st.last_piece) begin
				next_st.piece = st.piece + 2'h1;
				idle = idle_count(cfg, st.space, 1'b0);
				next_st.phase = (idle != 4'h0) ? ST_SETUP : ST_FIRST;
				next_st.cnt = idle - 4'h1;
			end else begin
				next_st.phase = ST_IDLE;
			end
		end

		// Output pins follow the next phase so they leave flops aligned
		next_st.resp.ready = (next_st.phase == ST_IDLE);
		next_st.pins.addr = next_st.addr
			+ 25'((next_st.width == WIDTH_32) ? 2'h0 : (next_st.width == WIDTH_16)
			? {next_st.piece[0], 1'b0} : next_st.piece);
		next_st.pins.bus_start_strobe_n = !(next_st.phase == ST_FIRST);
		// strobes only in first, wait and second states
		next_st.pins.read_strobe_n = !(!next_st.write && (next_st.phase == ST_FIRST
			|| next_st.phase == ST_WAIT || next_st.phase == ST_SECOND));
		mask = (next_st.last_piece != 2'h0) ? lane_mask(next_st.width, SIZE_LONG, 2'h0)
			: lane_mask(next_st.width, next_st.size, next_st.addr[1:0]);
		next_st.pins.byte_write_strobe_n = (next_st.write && (next_st.phase == ST_FIRST
			|| next_st.phase == ST_WAIT || next_st.phase == ST_SECOND)) ? ~mask : 4'hf;
		next_st.pins.rd_wr_n = !(next_st.write && next_st.phase != ST_IDLE);
		next_st.pins.data_oe = next_st.write && next_st.phase != ST_IDLE;
		shift = 5'((next_st.last_piece - next_st.piece) * ((next_st.width == WIDTH_16)
			? 5'h10 : 5'h8));
		next_st.pins.data_out = next_st.wdata >> shift;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st.phase <= ST_IDLE;
			st.cnt <= 4'h0;
			st.piece <= 2'h0;
			st.last_piece <= 2'h0;
			st.write <= 1'b0;
			st.size <= SIZE_BYTE;
			st.space <= 3'h0;
			st.width <= WIDTH_8;
			st.addr <= RESET_ADDR;
			st.wdata <= RESET_DATA;
			st.pins <= {RESET_ADDR, 1'b1, 1'b1, 4'hf, 1'b1, RESET_DATA, 1'b0};
			st.resp <= {1'b1, 1'b0, 1'b0, RESET_DATA};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Chip select
	// ----------------------------------------------------------------
	// cut at falling edge of the piece's last cycle, kept in bursts
	always_comb begin
		cs_request = 5'h0;
		if (st.phase != ST_IDLE && !piece_end) begin
			cs_request[st.space] = 1'b1;
		end
	end

	fall_edge_stage u_fall (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.wait_pin_n(wait_pin_n),
		.cs_request(cs_request),
		.wait_active(wait_active),
		.space_chip_select_n(space_chip_select_n)
	);

	assign pins = st.pins;
	assign resp = st.resp;

endmodule // ordinary_space_ctrl

/* testbench/ordinary_space_chk.sv */
// Port-level assertions for the ordinary-space bus cycle generator
`timescale 1ns/1ps
module ordinary_space_chk
	import ordinary_bus_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input bus_req_t req,
	input bus_cfg_t cfg,
	input wire logic wait_pin_n,
	input wire logic [31:0] bus_data_in,
	input bus_resp_t resp,
	input bus_pins_t pins,
	input wire logic [4:0] space_chip_select_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Plain 32-bit read taken on space 0 with no waits or idles
	wire plain_rd = resp.ready && req.valid && !req.write && req.space == 3'h0 &&
		cfg.wait_field[0] == WAIT_NONE && cfg.setup_hold_idle[0] == 2'h0 &&
		cfg.dev_width[0] == WIDTH_32;
	a_start_one_cycle: assert property ($fell(pins.bus_start_strobe_n) |=>
		pins.bus_start_strobe_n) else $error("start strobe longer than one cycle");
	a_two_cycle_read: assert property (plain_rd |=> !pins.bus_start_strobe_n
		##1 pins.bus_start_strobe_n ##1 (resp.rvalid && resp.ready))
		else $error("plain read not done in two cycles");
	a_cs_second_gap: assert property (plain_rd |=> !space_chip_select_n[0]
		##1 space_chip_select_n[0]) else $error("chip select not released in second state");
	a_idle_read_dir: assert property (resp.ready |-> pins.rd_wr_n)
		else $error("direction not at read level while idle");
	a_read_no_write: assert property (!pins.read_strobe_n |->
		&pins.byte_write_strobe_n) else $error("write strobe during read");
	a_write_data_drive: assert property (!(&pins.byte_write_strobe_n) |->
		pins.data_oe && !pins.rd_wr_n) else $error("write strobe without data drive");
	a_setup_no_strobe: assert property ($fell(resp.ready) && pins.bus_start_strobe_n |->
		pins.read_strobe_n && (&pins.byte_write_strobe_n))
		else $error("strobe asserted in setup idle");
	a_piece_pulse: assert property (resp.rvalid |=> !resp.rvalid)
		else $error("read piece pulse too long");
	a_burst_cs_held: assert property (cfg.ratio_one_to_one && !pins.bus_start_strobe_n &&
		!$past(resp.ready) |-> !(&space_chip_select_n) && !$past(&space_chip_select_n))
		else $error("chip select gap inside a burst");
endmodule // ordinary_space_chk

/* testbench/sram_model.sv */
// Behavioural external memory and wait source
`timescale 1ns/1ps
module sram_model
	import ordinary_bus_pkg::*;
(
	input wire logic clk_sys,
	input bus_pins_t pins,
	input wire logic [4:0] space_chip_select_n,
	input wire logic [3:0] stall,
	output logic [31:0] bus_data_in,
	output logic wait_pin_n
);
	logic [3:0] cnt = 4'h0;
	initial bus_data_in = 32'h0;
	assign wait_pin_n = (cnt == 4'h0);
	always @(posedge clk_sys) begin
		if (!pins.read_strobe_n && !(&space_chip_select_n))
			bus_data_in <= {4{pins.addr[7:0]}} ^ 32'h5a3c0f96;
		else
			bus_data_in <= ~bus_data_in;
		// Holds wait low a set span after each start
		if (!pins.bus_start_strobe_n)
			cnt <= stall;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
endmodule // sram_model

/* testbench/tb.sv */
// Self-checking bench for the ordinary-space bus cycle generator
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb
	import ordinary_bus_pkg::*;
;
	typedef struct packed {
		logic [7:0] lat;
		logic ge;
		logic [3:0] pl;
		logic [3:0] wm;
		logic [31:0] rd;
		logic [31:0] rm;
	} note_t;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	bus_req_t req = '0;
	bus_cfg_t cfg = '0;
	logic [31:0] bus_data_in;
	logic wait_pin_n;
	bus_resp_t resp;
	bus_pins_t pins;
	logic [4:0] space_chip_select_n;
	logic [3:0] stall = 4'h0;
	int failures = 0;
	int checked = 0;
	note_t q[$];
	note_t n;
	logic [7:0] cyc = 8'h0;
	logic [3:0] pl = 4'h0;
	logic [3:0] wm = 4'h0;
	logic [31:0] rd = 32'h0;
	logic prev = 1'b1;
	initial forever #50 clk_sys = ~clk_sys;
	ordinary_space_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .cfg(cfg),
		.wait_pin_n(wait_pin_n), .bus_data_in(bus_data_in), .resp(resp), .pins(pins),
		.space_chip_select_n(space_chip_select_n));
	sram_model mem (.clk_sys(clk_sys), .pins(pins), .space_chip_select_n(space_chip_select_n),
		.stall(stall), .bus_data_in(bus_data_in), .wait_pin_n(wait_pin_n));
	function automatic logic [3:0] pcs(input logic [1:0] wd, input logic [1:0] sz);
		if (wd == WIDTH_8)
			return (sz == SIZE_LONG) ? 4'h4 : (sz == SIZE_WORD) ? 4'h2 : 4'h1;
		return (wd == WIDTH_16 && sz == SIZE_LONG) ? 4'h2 : 4'h1;
	endfunction
	function automatic logic [3:0] wmx(input logic [1:0] wd, input logic [1:0] sz,
		input logic [1:0] a);
		if (wd == WIDTH_32)
			return (sz == SIZE_LONG) ? 4'hf : (sz == SIZE_WORD) ? (a[1] ? 4'h3 : 4'hc) : 4'h8 >> a;
		if (wd == WIDTH_16)
			return (sz == SIZE_BYTE) ? (a[0] ? 4'h1 : 4'h2) : 4'h3;
		return 4'h1;
	endfunction
	task automatic acc(input logic w, input logic [1:0] sz, input logic [2:0] sp,
		input logic [7:0] lat, input logic ge);
		logic [24:0] a;
		logic [24:0] la;
		logic [3:0] p;
		logic [1:0] wd;
		logic [31:0] d;
		note_t e;
		int k;
		@(posedge clk_sys);
		wd = cfg.dev_width[sp];
		p = pcs(wd, sz);
		d = $urandom;
		a = 25'($urandom) & ~25'((1 << sz) - 1);
		la = a + 25'((p - 4'h1) << wd);
		// Split accesses only get a lower bound on length
		e.lat = (p == 4'h1) ? lat : 8'(2 * p);
		e.ge = ge || (p != 4'h1);
		e.pl = p;
		e.wm = w ? wmx(wd, sz, a[1:0]) : 4'h0;
		e.rd = w ? d : {4{la[7:0]}} ^ 32'h5a3c0f96;
		e.rm = w ? 32'hffffffff : (wd == WIDTH_32) ? 32'hffffffff : (wd == WIDTH_16) ? 32'hffff
			: 32'hff;
		q.push_back(e);
		req <= '{1'b1, w, sz, sp, a, d};
		do @(posedge clk_sys); while (resp.ready !== 1'b1);
		req.valid <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (resp.ready !== 1'b1 && k < 300);
		if (resp.ready !== 1'b1) begin
			failures++;
			wrap_up;
		end
	endtask
	task wrap_up;
		if (q.size() != 0)
			failures++;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----
	// Result watcher
	// ----
	always @(posedge clk_sys) begin
		if (!sys_rst) begin
			if (req.valid && resp.ready) begin
				cyc = 8'h0;
				pl = 4'h0;
				wm = 4'h0;
			end else begin
				cyc++;
				pl += 4'(!pins.bus_start_strobe_n);
				wm |= ~pins.byte_write_strobe_n;
				if (resp.rvalid === 1'b1)
					rd = resp.rdata;
				if (pins.data_oe === 1'b1)
					rd = pins.data_out;
			end
			if (resp.ready === 1'b1 && !prev && q.size() > 0) begin
				n = q.pop_front();
				if (n.ge)
					`CHK(cyc > n.lat, 1'b1)
				else
					`CHK(cyc, n.lat)
				`CHK(pl, n.pl)
				`CHK(wm, n.wm)
				`CHK(rd & n.rm, n.rd & n.rm)
				`CHK(resp.last, 1'b1)
			end
			prev = resp.ready;
		end
	end
	initial begin
		#2000000;
		failures++;
		wrap_up;
	end
	initial begin
		void'($urandom(32'hc1f2eabd));
		cfg.dev_width <= {5{WIDTH_32}};
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		// lanes and splits at both ratios
		for (int r = 0; r < 2; r++)
			for (int wd = 0; wd < 3; wd++)
				for (int s = 0; s < 6; s++) begin
					cfg.ratio_one_to_one <= r[0];
					cfg.dev_width[0] <= wd[1:0];
					acc(s[0], 2'(s >> 1), 3'h0, 8'h3, 1'b0);
				end
		$display("test lanes done");
		cfg.dev_width[0] <= WIDTH_32;
		for (int c = 1; c < 3; c++) begin
			cfg.wait_field[0] <= c[1:0];
			acc(1'b0, SIZE_LONG, 3'h0, 8'(3 + c), 1'b0);
		end
		cfg.wait_field[1] <= WAIT_LONG;
		cfg.wait_field[4] <= WAIT_LONG;
		for (int c = 0; c < 8; c++) begin
			cfg.long_wait_sp1 <= c[2:0];
			cfg.long_wait_sp4 <= c[2:0];
			acc(1'b0, SIZE_LONG, 3'h1, 8'h3 + 8'(LONG_WAIT_TABLE[4 * c +: 4]), 1'b0);
			acc(1'b1, SIZE_LONG, 3'h4, 8'h3 + 8'(LONG_WAIT_TABLE[4 * c +: 4]), 1'b0);
		end
		// spaces 2 and 3 share one field
		cfg.wait_field[2] <= WAIT_LONG;
		cfg.wait_field[3] <= WAIT_LONG;
		cfg.shared_long_wait_sp23 <= 3'h5;
		acc(1'b0, SIZE_LONG, 3'h2, 8'h9, 1'b0);
		acc(1'b1, SIZE_LONG, 3'h3, 8'h9, 1'b0);
		$display("test waits done");
		cfg.wait_field[0] <= WAIT_SOFT_A;
		stall <= 4'h6;
		acc(1'b0, SIZE_LONG, 3'h0, 8'h4, 1'b1);
		cfg.external_wait_mask[0] <= 1'b1;
		acc(1'b0, SIZE_LONG, 3'h0, 8'h4, 1'b0);
		cfg.external_wait_mask[0] <= 1'b0;
		cfg.wait_field[0] <= WAIT_LONG;
		cfg.long_wait_sp0 <= 3'h2;
		acc(1'b0, SIZE_LONG, 3'h0, 8'h5, 1'b0);
		stall <= 4'h0;
		cfg.wait_field[4] <= WAIT_SOFT_A;
		for (int c = 0; c < 4; c++) begin
			cfg.sp4_wait_release_delay <= c[1:0];
			acc(1'b0, SIZE_LONG, 3'h4, 8'h3 + 8'(SP4_RELEASE_TABLE[4 * c +: 4]), 1'b0);
		end
		$display("test wait pin done");
		cfg.wait_field[1] <= WAIT_NONE;
		for (int k = 0; k < 4; k++) begin
			cfg.setup_hold_idle[1] <= k[1:0];
			acc(1'b1, SIZE_WORD, 3'h1, 8'(3 + 2 * ((k > 2) ? 2 : k)), 1'b0);
			acc(1'b0, SIZE_BYTE, 3'h1, 8'(3 + 2 * ((k > 2) ? 2 : k)), 1'b0);
		end
		cfg.wait_field[4] <= WAIT_NONE;
		cfg.sp4_setup_idle_count <= 3'h7;
		for (int h = 0; h < 4; h++) begin
			cfg.sp4_hold_idle_count <= h[1:0];
			acc(1'b1, SIZE_LONG, 3'h4, 8'ha + 8'(SP4_HOLD_TABLE[4 * h +: 4]), 1'b0);
		end
		$display("test idles done");
		repeat (3) @(posedge clk_sys);
		wrap_up;
	end
endmodule // tb
bind ordinary_space_ctrl ordinary_space_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.req(req), .cfg(cfg), .wait_pin_n(wait_pin_n), .bus_data_in(bus_data_in), .resp(resp),
	.pins(pins), .space_chip_select_n(space_chip_select_n));
